// File: rtl/rsm_core.sv
// Ring status messaging unit: origination, forwarding, supervision
// Behaviour
// - Dual channel: send own message on both
// - Single channel: send on channel zero only
// - Foreign sender id: forward message onward
// - Integrity message at least every 1000 ms
// - Status change sent at once unless busy
// - Ring mode: flag break if own messages lost
// - Offline flag per each of 16 peers
// - Own messages carry local node id
// - 128 kbps only on fibre cards, else 64
// - All linked nodes use same line rate
// - Channel line rates can differ via fixed_rate_ch_i
// - G.703/RS422 channels fixed at 64 kbps
// - Bridge passes channel zero traffic to one and channel one traffic to zero
// - Each hop adds one message slot delay
// - Check incoming CRC-32, drop corrupted messages
`timescale 1ns/1ps
module rsm_core #(
  parameter int SLOT_CYC_HI   = rsm_pkg::SLOT_CYC_HI,
  parameter int SLOT_CYC_LO   = rsm_pkg::SLOT_CYC_LO,
  parameter int INTEGRITY_CYC = rsm_pkg::INTEGRITY_CYC,
  parameter int MS_CYC        = rsm_pkg::MS_CYC,
  parameter int OFFLINE_MS    = rsm_pkg::OFFLINE_MS,
  parameter int RING_MS       = rsm_pkg::RING_MS,
  parameter int FIFO_DEPTH    = rsm_pkg::FIFO_DEPTH
) (
  input  wire logic                                  clk_i,
  input  wire logic                                  nrst_i,
  input  wire logic [rsm_pkg::ID_W-1:0]              local_node_id_i,
  input  wire logic                                  dual_channel_i,
  input  wire logic                                  ring_mode_i,
  input  wire logic                                  channel_bridge_enable_i,
  input  wire logic                                  rate_high_i,
  input  wire logic                                  fibre_card_i,
  input  wire logic [1:0]                            fixed_rate_ch_i,
  input  wire logic [rsm_pkg::STAT_W-1:0]            status_i,
  output logic      [1:0]                            tx_valid_o,
  output logic      [1:0][rsm_pkg::MSG_W-1:0]        tx_data_o,
  input  wire logic [1:0]                            rx_valid_i,
  input  wire logic [1:0][rsm_pkg::MSG_W-1:0]        rx_data_i,
  output logic      [1:0]                            rx_ready_o,
  output logic      [1:0]                            rate_high_active_o,
  output logic      [1:0]                            crc_err_o,
  output logic                                       ring_break_o,
  output logic      [rsm_pkg::NODES-1:0]             peer_offline_o
);

  localparam int PACE_W  = $clog2(SLOT_CYC_LO + 1);
  localparam int INTEG_W = $clog2(INTEGRITY_CYC + 1);
  localparam int MS_W    = $clog2(MS_CYC + 1);
  localparam int AGE_W   = rsm_pkg::AGE_W;
  localparam int MSG_W   = rsm_pkg::MSG_W;
  localparam int MASK_W_C = rsm_pkg::MASK_W;

  localparam logic [INTEG_W-1:0] INTEG_RELOAD = INTEG_W'(INTEGRITY_CYC - SLOT_CYC_LO - 1);
  localparam logic [AGE_W-1:0]   OFF_LIMIT    = AGE_W'(OFFLINE_MS);
  localparam logic [AGE_W-1:0]   RING_LIMIT   = AGE_W'(RING_MS);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [1:0][PACE_W-1:0]         pace_reg;
  logic [1:0][PACE_W-1:0]         pace_next;
  logic [1:0][PACE_W-1:0]         slot_len;
  logic [1:0]                     tx_valid_reg;
  logic [1:0]                     tx_valid_next;
  logic [1:0][MSG_W-1:0]          tx_data_reg;
  logic [1:0][MSG_W-1:0]          tx_data_next;
  logic                           pend_reg;
  logic                           pend_next;
  logic [INTEG_W-1:0]             integ_reg;
  logic [INTEG_W-1:0]             integ_next;
  logic [rsm_pkg::STAT_W-1:0]     sent_stat_reg;
  logic [rsm_pkg::STAT_W-1:0]     sent_stat_next;

  logic [1:0]                     en_mask;
  logic [1:0]                     ch_free;
  logic [1:0]                     fwd_mask_eff;
  logic                           local_go;
  logic                           fwd_go;
  logic [rsm_pkg::CRC_W-1:0]      tx_crc;
  logic [MSG_W-1:0]               local_msg;

  logic                           fifo_in_valid;
  logic                           fifo_in_ready;
  logic [rsm_pkg::FWD_W-1:0]      fifo_in_data;
  logic                           fifo_out_valid;
  logic                           fifo_out_ready;
  logic [rsm_pkg::FWD_W-1:0]      fifo_out_data;

  logic [1:0][rsm_pkg::CRC_W-1:0] rx_crc;
  logic [1:0]                     crc_ok;
  logic [1:0]                     foreign;
  logic [1:0]                     fwd_need;
  logic [1:0]                     grant;
  logic [1:0]                     take;
  logic [1:0][MASK_W_C-1:0]       rx_mask;

  logic [MS_W-1:0]                ms_reg;
  logic [MS_W-1:0]                ms_next;
  logic                           ms_tick;
  logic [rsm_pkg::NODES-1:0][AGE_W-1:0] age_reg;
  logic [rsm_pkg::NODES-1:0][AGE_W-1:0] age_next;
  logic [AGE_W-1:0]               ring_age_reg;
  logic [AGE_W-1:0]               ring_age_next;
  logic [rsm_pkg::NODES-1:0]      offline_reg;
  logic [rsm_pkg::NODES-1:0]      offline_next;
  logic                           ring_break_reg;
  logic                           ring_break_next;
  logic [1:0]                     crc_err_reg;
  logic [1:0]                     crc_err_next;
  logic                           seen;
  logic                           own_back;
  logic [rsm_pkg::ID_W-1:0]       seen_id;

  function automatic logic [rsm_pkg::ID_W-1:0] sender_of(input logic [MSG_W-1:0] m);
    sender_of = m[rsm_pkg::ID_LSB +: rsm_pkg::ID_W];
  endfunction

  // ------------------------------------------------------------
  // Line rate per channel
  // ------------------------------------------------------------
  // One rate setting per node
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      rate_high_active_o[c] = rate_high_i && fibre_card_i && !fixed_rate_ch_i[c];
      slot_len[c] = rate_high_active_o[c] ? PACE_W'(SLOT_CYC_HI - 1)
                                          : PACE_W'(SLOT_CYC_LO - 1);
      ch_free[c]  = (pace_reg[c] == '0);
    end
  end

  // ------------------------------------------------------------
  // Local message build
  // ------------------------------------------------------------
  rsm_crc32 #(
    .DW (rsm_pkg::PAY_W)
  ) u_tx_crc (
    .data_i ({local_node_id_i, status_i}),
    .crc_o  (tx_crc)
  );

  assign local_msg = {local_node_id_i, status_i, tx_crc};

  assign en_mask      = dual_channel_i ? 2'h3 : 2'h1;
  assign local_go     = &(ch_free | ~en_mask);
  assign fwd_mask_eff = fifo_out_data[MSG_W +: MASK_W_C] & en_mask;
  assign fwd_go       = &(ch_free | ~fwd_mask_eff);

  // ------------------------------------------------------------
  // Transmit scheduling
  // ------------------------------------------------------------
  always_comb begin
    pace_next      = pace_reg;
    tx_valid_next  = '0;
    tx_data_next   = tx_data_reg;
    sent_stat_next = sent_stat_reg;
    fifo_out_ready = 1'b0;
    integ_next     = (integ_reg == '0) ? integ_reg : integ_reg - 1'b1;
    pend_next      = pend_reg || (status_i != sent_stat_reg) || (integ_reg == '0);
    for (int c = 0; c < 2; c++) begin
      if (!ch_free[c]) begin
        pace_next[c] = pace_reg[c] - 1'b1;
      end
    end
    if (pend_reg && local_go) begin
      for (int c = 0; c < 2; c++) begin
        if (en_mask[c]) begin
          tx_valid_next[c] = 1'b1;
          tx_data_next[c]  = local_msg;
          pace_next[c]     = slot_len[c];
        end
      end
      sent_stat_next = status_i;
      pend_next      = 1'b0;
      integ_next     = INTEG_RELOAD;
    end else if (fifo_out_valid && fwd_go) begin
      fifo_out_ready = 1'b1;
      for (int c = 0; c < 2; c++) begin
        if (fwd_mask_eff[c]) begin
          tx_valid_next[c] = 1'b1;
          tx_data_next[c]  = fifo_out_data[MSG_W-1:0];
          pace_next[c]     = slot_len[c];
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pace_reg      <= '0;
      tx_valid_reg  <= '0;
      tx_data_reg   <= '0;
      pend_reg      <= 1'b1;
      integ_reg     <= '0;
      sent_stat_reg <= '0;
    end else begin
      pace_reg      <= pace_next;
      tx_valid_reg  <= tx_valid_next;
      tx_data_reg   <= tx_data_next;
      pend_reg      <= pend_next;
      integ_reg     <= integ_next;
      sent_stat_reg <= sent_stat_next;
    end
  end

  // ------------------------------------------------------------
  // Transmit outputs
  // ------------------------------------------------------------
  // One-cycle send pulse
  assign tx_valid_o = tx_valid_reg;
  assign tx_data_o  = tx_data_reg;

  // ------------------------------------------------------------
  // Receive check and arbitration
  // ------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_rx
    rsm_crc32 #(
      .DW (rsm_pkg::PAY_W)
    ) u_rx_crc (
      .data_i (rx_data_i[g][MSG_W-1:rsm_pkg::CRC_W]),
      .crc_o  (rx_crc[g])
    );
  end

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      crc_ok[c]   = (rx_crc[c] == rx_data_i[c][rsm_pkg::CRC_LSB +: rsm_pkg::CRC_W]);
      foreign[c]  = (sender_of(rx_data_i[c]) != local_node_id_i);
      fwd_need[c] = crc_ok[c] && foreign[c];
    end
    grant[0]      = 1'b1;
    grant[1]      = !rx_valid_i[0];
    for (int c = 0; c < 2; c++) begin
      rx_ready_o[c] = grant[c] && (!fwd_need[c] || fifo_in_ready);
      take[c]       = rx_valid_i[c] && rx_ready_o[c];
    end
    rx_mask[0]    = {channel_bridge_enable_i && dual_channel_i, 1'b1};
    rx_mask[1]    = {1'b1, channel_bridge_enable_i};
    fifo_in_valid = (rx_valid_i[0] && fwd_need[0]) ||
                    (grant[1] && rx_valid_i[1] && fwd_need[1]);
    fifo_in_data  = rx_valid_i[0] ? {rx_mask[0], rx_data_i[0]} : {rx_mask[1], rx_data_i[1]};
  end

  rsm_fifo #(
    .W     (rsm_pkg::FWD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fwd_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (fifo_in_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  // ------------------------------------------------------------
  // Peer and ring supervision
  // ------------------------------------------------------------
  always_comb begin
    ms_tick  = (ms_reg == '0);
    ms_next  = ms_tick ? MS_W'(MS_CYC - 1) : ms_reg - 1'b1;
    seen     = (take[0] && crc_ok[0] && foreign[0]) || (take[1] && crc_ok[1] && foreign[1]);
    own_back = (take[0] && crc_ok[0] && !foreign[0]) ||
               (take[1] && crc_ok[1] && !foreign[1]);
    seen_id  = take[0] ? sender_of(rx_data_i[0]) : sender_of(rx_data_i[1]);
    for (int c = 0; c < 2; c++) begin
      crc_err_next[c] = take[c] && !crc_ok[c];
    end
    for (int p = 0; p < rsm_pkg::NODES; p++) begin
      age_next[p] = age_reg[p];
      if (seen && (seen_id == rsm_pkg::ID_W'(p))) begin
        age_next[p] = '0;
      end else if (ms_tick && (age_reg[p] < OFF_LIMIT)) begin
        age_next[p] = age_reg[p] + 1'b1;
      end
      offline_next[p] = (age_next[p] >= OFF_LIMIT) && (local_node_id_i != rsm_pkg::ID_W'(p));
    end
    ring_age_next = ring_age_reg;
    if (!ring_mode_i || own_back) begin
      ring_age_next = '0;
    end else if (ms_tick && (ring_age_reg < RING_LIMIT)) begin
      ring_age_next = ring_age_reg + 1'b1;
    end
    ring_break_next = ring_mode_i && (ring_age_next >= RING_LIMIT);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ms_reg         <= '0;
      age_reg        <= '0;
      ring_age_reg   <= '0;
      offline_reg    <= '0;
      ring_break_reg <= 1'b0;
      crc_err_reg    <= '0;
    end else begin
      ms_reg         <= ms_next;
      age_reg        <= age_next;
      ring_age_reg   <= ring_age_next;
      offline_reg    <= offline_next;
      ring_break_reg <= ring_break_next;
      crc_err_reg    <= crc_err_next;
    end
  end

  // ------------------------------------------------------------
  // Flag outputs
  // ------------------------------------------------------------
  assign peer_offline_o = offline_reg;
  assign ring_break_o   = ring_break_reg;
  assign crc_err_o      = crc_err_reg;

endmodule // rsm_core

// File: rtl/rsm_pkg.sv
// Shared constants for the ring status messaging block
package rsm_pkg;

  // ------------------------------------------------------------
  // Message layout: {sender id, status bits, crc}
  // ------------------------------------------------------------
  localparam int ID_W      = 4;
  localparam int STAT_W    = 16;
  localparam int NODES     = 16;
  localparam int PAY_W     = ID_W + STAT_W;
  localparam int CRC_W     = 32;
  localparam int MSG_W     = PAY_W + CRC_W;
  localparam int CRC_LSB   = 0;
  localparam int STAT_LSB  = CRC_W;
  localparam int ID_LSB    = CRC_W + STAT_W;
  localparam int MASK_W    = 2;
  localparam int FWD_W     = MSG_W + MASK_W;
  localparam int FIFO_DEPTH = 8;

  localparam logic [CRC_W-1:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [CRC_W-1:0] CRC_INIT = 32'hFFFFFFFF;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int RATE_HI_BPS   = 128_000;
  localparam int RATE_LO_BPS   = 64_000;
  localparam int BIT_CYC_HI    = CLK_HZ / RATE_HI_BPS;
  localparam int BIT_CYC_LO    = CLK_HZ / RATE_LO_BPS;
  localparam int SLOT_CYC_HI   = MSG_W * BIT_CYC_HI;
  localparam int SLOT_CYC_LO   = MSG_W * BIT_CYC_LO;
  localparam int MS_CYC        = CLK_HZ / 1000;
  localparam int INTEGRITY_MS  = 1000;
  localparam int INTEGRITY_CYC = INTEGRITY_MS * MS_CYC;
  localparam int OFFLINE_MS    = 3000;
  localparam int RING_MS       = 3000;
  localparam int AGE_W         = 12;

endpackage

// File: rtl/rsm_crc32.sv
// CRC-32 over a message payload, combinational
`timescale 1ns/1ps
module rsm_crc32 #(
  parameter int DW = rsm_pkg::PAY_W
) (
  input  wire logic [DW-1:0]              data_i,
  output logic      [rsm_pkg::CRC_W-1:0]  crc_o
);

  logic [rsm_pkg::CRC_W-1:0] c;
  logic                      fb;

  // ------------------------------------------------------------
  // Bitwise shift, MSB first
  // ------------------------------------------------------------
  always_comb begin
    c  = rsm_pkg::CRC_INIT;
    fb = 1'b0;
    for (int i = DW - 1; i >= 0; i--) begin
      fb = c[rsm_pkg::CRC_W-1] ^ data_i[i];
      c  = {c[rsm_pkg::CRC_W-2:0], 1'b0};
      if (fb) begin
        c = c ^ rsm_pkg::CRC_POLY;
      end
    end
    crc_o = c;
  end

endmodule // rsm_crc32

// File: rtl/rsm_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rsm_fifo #(
  parameter int W     = rsm_pkg::FWD_W,
  parameter int DEPTH = rsm_pkg::FIFO_DEPTH
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_reg;
  logic [AW:0]  wr_next;
  logic [AW:0]  rd_reg;
  logic [AW:0]  rd_next;
  logic         push;
  logic         pop;

  // ------------------------------------------------------------
  // Pointers with wrap bit
  // ------------------------------------------------------------
  always_comb begin
    out_valid_o = (wr_reg != rd_reg);
    in_ready_o  = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wr_next     = push ? wr_reg + 1'b1 : wr_reg;
    rd_next     = pop ? rd_reg + 1'b1 : rd_reg;
    out_data_o  = mem[rd_reg[AW-1:0]];
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data_i;
    end
  end

endmodule // rsm_fifo

// File: test/rsm_peer.sv
// Far-side peer model for one serial channel
`timescale 1ns/1ps
module rsm_peer (
  input  wire logic                      clk_i,
  input  wire logic                      loop_i,
  input  wire logic                      tx_valid_i,
  input  wire logic [rsm_pkg::MSG_W-1:0] tx_data_i,
  input  wire logic                      rx_ready_i,
  output logic                           rx_valid_o,
  output logic      [rsm_pkg::MSG_W-1:0] rx_data_o
);
  logic [rsm_pkg::MSG_W-1:0] q[$];
  logic                      took;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = '0;
    took       = 1'b0;
  end
  task automatic send(input logic [rsm_pkg::MSG_W-1:0] m);
    q.push_back(m);
  endtask
  always @(posedge clk_i) begin
    took <= rx_valid_o && rx_ready_i;
    if (loop_i && tx_valid_i) q.push_back(tx_data_i);
  end
  // same rate, offer held until taken
  always @(negedge clk_i) begin
    if (took || !rx_valid_o) begin
      if (q.size() > 0) begin
        rx_valid_o = 1'b1;
        rx_data_o  = q.pop_front();
      end else begin
        rx_valid_o = 1'b0;
        rx_data_o  = ~rx_data_o;
      end
    end
  end
endmodule // rsm_peer

// File: test/rsm_core_properties.sv
// Port-level assertions for the ring status messaging core
`timescale 1ns/1ps
module rsm_core_properties #(
  parameter int SLOT_CYC_HI   = rsm_pkg::SLOT_CYC_HI,
  parameter int SLOT_CYC_LO   = rsm_pkg::SLOT_CYC_LO,
  parameter int INTEGRITY_CYC = rsm_pkg::INTEGRITY_CYC
) (
  input wire logic                           clk_i,
  input wire logic                           nrst_i,
  input wire logic [rsm_pkg::ID_W-1:0]       local_node_id_i,
  input wire logic                           dual_channel_i,
  input wire logic                           ring_mode_i,
  input wire logic                           rate_high_i,
  input wire logic                           fibre_card_i,
  input wire logic [1:0]                     fixed_rate_ch_i,
  input wire logic [rsm_pkg::STAT_W-1:0]     status_i,
  input wire logic [1:0]                     tx_valid_o,
  input wire logic [1:0][rsm_pkg::MSG_W-1:0] tx_data_o,
  input wire logic [1:0]                     rx_valid_i,
  input wire logic [1:0]                     rx_ready_o,
  input wire logic [1:0]                     rate_high_active_o,
  input wire logic [1:0]                     crc_err_o,
  input wire logic                           ring_break_o,
  input wire logic [rsm_pkg::NODES-1:0]      peer_offline_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  int                         idle_reg;
  int                         gap_reg;
  int                         chg_reg;
  logic [rsm_pkg::STAT_W-1:0] st_reg;
  logic                       own0;
  assign own0 = tx_valid_o[0] && tx_data_o[0][51:48] == local_node_id_i;
  // ------------------------------------------------------------
  // Cycle counters since last send, last own send and last status change
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_reg <= 0;
      gap_reg  <= SLOT_CYC_HI;
      chg_reg  <= 0;
      st_reg   <= '0;
    end else begin
      st_reg   <= status_i;
      idle_reg <= own0 ? 0 : idle_reg + 1;
      gap_reg  <= tx_valid_o[0] ? 0 : gap_reg + 1;
      chg_reg  <= own0 ? 0 : (status_i != st_reg || chg_reg != 0) ? chg_reg + 1 : 0;
    end
  end
  chk_rate_map: assert property (
    rate_high_active_o == ({2{rate_high_i & fibre_card_i}} & ~fixed_rate_ch_i))
    else $error("line rate selection wrong");
  chk_single_chan: assert property (
    !dual_channel_i && $past(!dual_channel_i) |-> !tx_valid_o[1])
    else $error("channel one sent while single");
  chk_dual_both: assert property (
    own0 && dual_channel_i && $past(dual_channel_i) |-> tx_valid_o[1] && tx_data_o[1] == tx_data_o[0])
    else $error("own message not on both channels");
  chk_slot_gap: assert property (
    tx_valid_o[0] |-> gap_reg >= SLOT_CYC_HI - 1)
    else $error("sends closer than one slot");
  chk_integrity_gap: assert property (
    idle_reg < INTEGRITY_CYC)
    else $error("integrity interval exceeded");
  chk_change_send: assert property (
    chg_reg <= SLOT_CYC_LO + 4)
    else $error("status change not sent");
  chk_crc_pulse: assert property (
    (crc_err_o & ~$past(rx_valid_i & rx_ready_o)) == 2'b00)
    else $error("crc error without taken message");
  chk_ready_prio: assert property (
    rx_valid_i[0] |-> !rx_ready_o[1])
    else $error("channel one taken during channel zero offer");
  chk_own_online: assert property (
    !peer_offline_o[local_node_id_i])
    else $error("own id flagged offline");
  chk_ring_idle: assert property (
    !ring_mode_i && $past(!ring_mode_i) |-> !ring_break_o)
    else $error("ring break outside ring mode");
  cover property (own0 && tx_valid_o[1]);
  cover property ($rose(ring_break_o));
  cover property (crc_err_o[0]);
  cover property (rx_valid_i[0] && !rx_ready_o[0]);
endmodule // rsm_core_properties

bind rsm_core rsm_core_properties #(
  .SLOT_CYC_HI(SLOT_CYC_HI), .SLOT_CYC_LO(SLOT_CYC_LO), .INTEGRITY_CYC(INTEGRITY_CYC)
) u_chk (
  .clk_i, .nrst_i, .local_node_id_i, .dual_channel_i, .ring_mode_i, .rate_high_i,
  .fibre_card_i, .fixed_rate_ch_i, .status_i, .tx_valid_o, .tx_data_o, .rx_valid_i,
  .rx_ready_o, .rate_high_active_o, .crc_err_o, .ring_break_o, .peer_offline_o
);

// File: test/tb_ring_status_messaging.sv
// Self-checking bench for the ring status messaging core
`timescale 1ns/1ps
module tb_ring_status_messaging;
  typedef logic [rsm_pkg::MSG_W-1:0] rsm_msg_t;
  localparam logic [3:0] LID = 4'h5;
  logic                   clk_i = 1'b0;
  logic                   nrst_i, dual_channel_i, ring_mode_i, channel_bridge_enable_i;
  logic                   rate_high_i, fibre_card_i, ring_break_o, loop;
  logic [3:0]             local_node_id_i, rid;
  logic [1:0]             fixed_rate_ch_i, tx_valid_o, rx_ready_o, rate_high_active_o, crc_err_o;
  logic [15:0]            status_i, peer_offline_o, s1;
  logic [1:0][51:0]       tx_data_o;
  wire logic [1:0]        rx_valid_i;
  wire logic [1:0][51:0]  rx_data_i;
  logic [31:0]            seed = 32'hC13C;
  logic [31:0]            r;
  logic [1:0]             dm;
  rsm_msg_t               m;
  rsm_msg_t               fq[2][$];
  int                     own_cnt[2];
  int                     crc_cnt, cycles, err_count, cmp_count, n0;

  always #5 clk_i = ~clk_i;

  rsm_core #(
    .SLOT_CYC_HI(20), .SLOT_CYC_LO(40), .INTEGRITY_CYC(400), .MS_CYC(10),
    .OFFLINE_MS(5)
  ) u_rsm_core (
    .clk_i, .nrst_i, .local_node_id_i, .dual_channel_i, .ring_mode_i,
    .channel_bridge_enable_i, .rate_high_i, .fibre_card_i, .fixed_rate_ch_i, .status_i,
    .tx_valid_o, .tx_data_o, .rx_valid_i, .rx_data_i, .rx_ready_o, .rate_high_active_o,
    .crc_err_o, .ring_break_o, .peer_offline_o
  );
  rsm_peer u_peer0 (.clk_i, .loop_i(loop), .tx_valid_i(tx_valid_o[0]), .tx_data_i(tx_data_o[0]),
    .rx_ready_i(rx_ready_o[0]), .rx_valid_o(rx_valid_i[0]), .rx_data_o(rx_data_i[0]));
  rsm_peer u_peer1 (.clk_i, .loop_i(loop), .tx_valid_i(tx_valid_o[1]), .tx_data_i(tx_data_o[1]),
    .rx_ready_i(rx_ready_o[1]), .rx_valid_o(rx_valid_i[1]), .rx_data_o(rx_data_i[1]));

  // ------------------------------------------------------------
  // Reference model, checks and closing
  // ------------------------------------------------------------
  function automatic rsm_msg_t mk(input logic [3:0] id, input logic [15:0] st);
    logic [31:0] c;
    logic [19:0] d;
    c = rsm_pkg::CRC_INIT;
    d = {id, st};
    for (int i = 19; i >= 0; i--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? rsm_pkg::CRC_POLY : 32'h0);
    end
    return {id, st, c};
  endfunction
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (exp !== got) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((fq[0].size() + fq[1].size() + u_peer0.q.size() + u_peer1.q.size() > 0
            || rx_valid_i != 2'b00) && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    check("forward queue", 0, fq[0].size() + fq[1].size());
  endtask
  task automatic change_status();
    r = xs();
    status_i = status_i ^ (r[15:0] | 16'h0001);
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      stop_test();
    end
    s1 <= status_i;
    for (int c = 0; c < 2; c++) begin
      if (nrst_i && rx_valid_i[c] && rx_ready_o[c]) begin
        m = rx_data_i[c];
        if (m === mk(m[51:48], m[47:32]) && m[51:48] !== LID) begin
          dm = (2'b01 << c) | (channel_bridge_enable_i ? (2'b10 >> c) : 2'b00);
          dm = dm & (dual_channel_i ? 2'b11 : 2'b01);
          for (int d = 0; d < 2; d++) if (dm[d]) fq[d].push_back(m);
        end
      end
    end
  end
  always @(negedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (nrst_i && crc_err_o[c] === 1'b1) crc_cnt++;
      if (nrst_i && tx_valid_o[c] === 1'b1) begin
        if (tx_data_o[c][51:48] === LID) begin
          own_cnt[c]++;
          check("own message", mk(LID, s1), tx_data_o[c]);
        end else if (fq[c].size() == 0) begin
          check("unexpected forward", 0, tx_data_o[c]);
        end else begin
          check("forwarded message", fq[c].pop_front(), tx_data_o[c]);
        end
      end
    end
  end

  initial begin
    nrst_i = 1'b0;
    loop = 1'b0;
    local_node_id_i = LID;
    {dual_channel_i, ring_mode_i, channel_bridge_enable_i} = 3'b000;
    {rate_high_i, fibre_card_i, fixed_rate_ch_i} = 4'h0;
    status_i = 16'h0000;
    repeat (6) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (500) @(negedge clk_i);
    check("integrity sends", 1, own_cnt[0] >= 2);
    check("channel one silent", 0, own_cnt[1]);
    n0 = own_cnt[0];
    change_status();
    repeat (50) @(negedge clk_i);
    check("change sent", 1, own_cnt[0] > n0);
    $display("Done single channel");
    dual_channel_i = 1'b1;
    change_status();
    repeat (50) @(negedge clk_i);
    check("channel one sends", 1, own_cnt[1] > 0);
    $display("Done dual channel");
    for (int k = 0; k < 12; k++) begin
      r = xs();
      rid = (r[19:16] == LID) ? 4'h6 : r[19:16];
      u_peer0.send(mk(rid, r[15:0]));
    end
    u_peer0.send(mk(4'h3, 16'h1234) ^ 52'h1);
    u_peer0.send(mk(LID, ~status_i));
    drain();
    channel_bridge_enable_i = 1'b1;
    for (int k = 0; k < 3; k++) begin
      r = xs();
      u_peer1.send(mk(4'h7, r[15:0]));
      u_peer0.send(mk(4'h8, r[31:16]));
    end
    drain();
    check("crc errors", 1, crc_cnt);
    $display("Done forwarding");
    repeat (100) @(negedge clk_i);
    check("peers offline", 16'hFFDF, peer_offline_o);
    u_peer0.send(mk(4'h3, 16'h00A5));
    repeat (10) @(negedge clk_i);
    check("peer back online", 16'hFFD7, peer_offline_o);
    $display("Done offline");
    ring_mode_i = 1'b1;
    repeat (30020) @(negedge clk_i);
    check("ring break set", 1, ring_break_o);
    loop = 1'b1;
    repeat (460) @(negedge clk_i);
    check("ring break clear", 0, ring_break_o);
    ring_mode_i = 1'b0;
    $display("Done ring");
    for (int k = 0; k < 16; k++) begin
      {rate_high_i, fibre_card_i, fixed_rate_ch_i} = k[3:0];
      @(negedge clk_i);
      check("line rate", {2{rate_high_i & fibre_card_i}} & ~fixed_rate_ch_i, rate_high_active_o);
    end
    $display("Done line rate");
    stop_test();
  end
endmodule // tb_ring_status_messaging
